// *** src/test_vector_pkg.sv ***
// =====================================================================
// Shared constants for the test vector bus master
// =====================================================================
// Holds register offsets, control vector fields, reset values and states.
// Assumes a 32-bit APB for registers and a 32-bit AHB-style master bus.
package test_vector_pkg;
   // APB register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STAT = 12'h004;
   localparam logic [11:0] OFF_ADDR = 12'h008;
   localparam logic [11:0] OFF_CFG = 12'h00C;
   // Control vector field positions
   localparam int CV_VALID = 0;
   localparam int CV_SIZE = 2;
   localparam int CV_LOCK = 4;
   localparam int CV_PROT_LO = 5;
   localparam int CV_INC = 7;
   localparam int CV_PROT_HI = 9;
   // Values after reset: word size, supervisor data, no cache, no buffer
   localparam logic [1:0] SIZE_RST = 2'h2;
   localparam logic [3:0] PROT_RST = 4'h3;
   localparam logic CTRL_EN_RST = 1'b1;
   // Bus transfer codes
   localparam logic [1:0] TR_IDLE = 2'h0;
   localparam logic [1:0] TR_NSEQ = 2'h2;
   localparam logic [1:0] TR_SEQ = 2'h3;
   localparam logic [2:0] BURST_INCR = 3'h1;
   // Vector types as {primary, secondary}
   localparam logic [1:0] VT_ADDR = 2'h3;
   localparam logic [1:0] VT_WR = 2'h2;
   localparam logic [1:0] VT_RD = 2'h1;
   localparam logic [1:0] VT_EXIT = 2'h0;
   // Turnaround vectors that follow a read
   localparam logic [1:0] TURN_CNT = 2'h2;
   // Interface mode and bus master states
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_RUN} mode_e;
   typedef enum logic [1:0] {AB_IDLE, AB_ADDR, AB_DATA} ahb_e;
endpackage

// *** src/test_vector_bus_master.sv ***
// =====================================================================
// Test vector bus master
// =====================================================================
// Turns tester vectors into transfers on the system bus as a master.
// Assumes the tester clock and pins are asynchronous to pclk and that
// an arbiter answers hbusreq with hgrant.
//
// Our own choices: the APB register port and the address map.
module test_vector_bus_master
   import test_vector_pkg::*;
#(
   parameter int AW = 32,
   parameter int DW = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Tester pins
   input wire logic external_test_clock,
   input wire logic tester_req_primary,
   input wire logic tester_req_secondary,
   output logic tester_acknowledge,
   input wire logic [DW-1:0] external_vector_bus_in,
   output logic [DW-1:0] external_vector_bus_out,
   output logic external_vector_bus_oe,
   // System bus master
   output logic hbusreq,
   output logic hlock,
   input wire logic hgrant,
   input wire logic hready,
   input wire logic [1:0] hresp,
   input wire logic [DW-1:0] hrdata,
   output logic [AW-1:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [2:0] hburst,
   output logic [3:0] hprot,
   output logic [DW-1:0] hwdata
);
   // Incrementer needs bits up to 9, control vector up to bit 10
   if (AW < 10 || AW > 32 || DW < 11 || DW > 32) begin : g_chk
      $error("AW must be 10..32 and DW 11..32");
   end

   // =====================================================================
   // Pin synchronisers
   // =====================================================================
   logic [2:0] clk_s; // Tester clock stages
   logic [2:0] pa_s; // Primary request stages
   logic [2:0] pb_s; // Secondary request stages
   logic [DW-1:0] bus_s1, bus_s2, bus_s3; // Vector bus stages
   logic tick; // One pclk pulse per tester clock rising edge

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_s <= 3'h0;
         pa_s <= 3'h0;
         pb_s <= 3'h0;
         bus_s1 <= '0;
         bus_s2 <= '0;
         bus_s3 <= '0;
      end else begin
         clk_s <= {clk_s[1:0], external_test_clock};
         pa_s <= {pa_s[1:0], tester_req_primary};
         pb_s <= {pb_s[1:0], tester_req_secondary};
         bus_s1 <= external_vector_bus_in;
         bus_s2 <= bus_s1;
         bus_s3 <= bus_s2;
      end
   end
   // Third data stage holds the value from just before the clock edge
   assign tick = clk_s[1] & ~clk_s[2];

   // =====================================================================
   // Vector decode and mode control
   // =====================================================================
   mode_e mode; // Interface mode
   ahb_e ab; // Bus master phase
   logic [1:0] req_prev; // Type of the vector now on the bus
   logic [1:0] req_now; // Type announced for the next cycle
   logic [1:0] turn_cnt; // Turnaround vectors still expected
   logic prev_addr; // Last vector applied an address
   logic addr_valid; // An address has been applied
   logic pend; // Transfer waiting for the bus
   logic dir; // Direction of pending or current transfer
   logic last_dir; // Direction of the previous transfer
   logic seq_ok; // Next transfer may be sequential
   logic busy; // Transfer not finished
   logic take; // Vector consumed at this tick
   logic is_ctrl; // Vector now on the bus is a control vector
   logic ctrl_en; // Software enable for test entry
   logic [AW-1:0] cur_addr; // Transfer address
   logic [DW-1:0] wdata_q; // Captured write data
   logic [1:0] size_cfg; // Transfer size
   logic [3:0] prot_cfg; // Protection bits
   logic lock_cfg; // Lock request
   logic inc_cfg; // Address increment enable
   logic [7:0] seg_now; // Current address segment, before the increment
   logic [8:0] seg_inc; // Segment plus one with carry
   logic [AW-1:0] seg_mask; // Segment position
   logic [AW-1:0] next_addr; // Address after increment

   assign req_now = {pa_s[2], pb_s[2]};
   assign busy = pend | (ab != AB_IDLE);
   assign take = tick & (mode == ST_RUN) & ~busy;
   // address-coded before read or write after an applied address is control
   assign is_ctrl = (req_prev == VT_ADDR) && (turn_cnt == 2'h0) && prev_addr
      && (req_now == VT_WR || req_now == VT_RD);

   // Mode, acknowledge and request handling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= ST_IDLE;
         tester_acknowledge <= 1'b0;
         hbusreq <= 1'b0;
      end else begin
         case (mode)
            ST_IDLE: begin
               tester_acknowledge <= 1'b0;
               hbusreq <= 1'b0;
               // Enter on synchronised primary request
               if (ctrl_en && pa_s[2]) begin
                  mode <= ST_START;
                  hbusreq <= 1'b1;
               end
            end
            ST_START: begin
               // acknowledge once the bus is won
               if (hgrant && hready) begin
                  mode <= ST_RUN;
                  tester_acknowledge <= 1'b1;
               end
            end
            ST_RUN: begin
               // keep the bus for the whole test
               hbusreq <= 1'b1;
               if (tick && busy) begin
                  tester_acknowledge <= 1'b0;
               end else if (!busy) begin
                  tester_acknowledge <= 1'b1;
               end
               if (take && req_prev == VT_EXIT) begin
                  mode <= ST_IDLE;
                  tester_acknowledge <= 1'b0;
                  hbusreq <= 1'b0;
               end
            end
            default: mode <= ST_IDLE;
         endcase
      end
   end

   // Vector pipeline and address, control capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_prev <= VT_ADDR;
         turn_cnt <= 2'h0;
         prev_addr <= 1'b0;
         addr_valid <= 1'b0;
         cur_addr <= '0;
         wdata_q <= '0;
         pend <= 1'b0;
         dir <= 1'b0;
         size_cfg <= SIZE_RST;
         prot_cfg <= PROT_RST;
         lock_cfg <= 1'b0;
         inc_cfg <= 1'b0;
      end else if (mode == ST_START) begin
         req_prev <= VT_ADDR;
         turn_cnt <= 2'h1;
         prev_addr <= 1'b0;
         addr_valid <= 1'b0;
      end else if (ab == AB_IDLE && pend && hgrant && hready) begin
         pend <= 1'b0;
      end else if (ab == AB_ADDR && hready && inc_cfg) begin
         cur_addr <= next_addr;
      end else if (take) begin
         // pins now name the next cycle
         req_prev <= req_now;
         prev_addr <= 1'b0;
         case (req_prev)
            VT_ADDR: begin
               if (turn_cnt != 2'h0) begin
                  turn_cnt <= turn_cnt - 2'h1;
               end else if (is_ctrl) begin
                  if (bus_s3[CV_VALID]) begin
                     size_cfg <= bus_s3[CV_SIZE +: 2];
                     lock_cfg <= bus_s3[CV_LOCK];
                     prot_cfg <= {bus_s3[CV_PROT_HI +: 2], bus_s3[CV_PROT_LO +: 2]};
                     inc_cfg <= bus_s3[CV_INC];
                  end
               end else begin
                  cur_addr <= AW'(bus_s3);
                  addr_valid <= 1'b1;
                  prev_addr <= 1'b1;
               end
            end
            VT_WR: begin
               wdata_q <= bus_s3;
               pend <= addr_valid;
               dir <= 1'b1;
            end
            VT_RD: begin
               pend <= addr_valid;
               dir <= 1'b0;
               turn_cnt <= TURN_CNT;
            end
            default: begin
               prev_addr <= 1'b0;
            end
         endcase
      end
   end

   // =====================================================================
   // Address incrementer
   // =====================================================================
   // Eight bits above the size alignment count; carry wraps the segment
   always_comb begin
      seg_now = 8'(cur_addr >> size_cfg);
      seg_inc = {1'b0, seg_now} + 9'h001;
      seg_mask = AW'(32'h0000_00FF) << size_cfg;
      next_addr = (cur_addr & ~seg_mask) | (AW'(seg_inc[7:0]) << size_cfg);
   end

   // =====================================================================
   // Bus master
   // =====================================================================
   // Address phase when granted, then data phase until hready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ab <= AB_IDLE;
         haddr <= '0;
         htrans <= TR_IDLE;
         hwrite <= 1'b0;
         hwdata <= '0;
         last_dir <= 1'b0;
         seq_ok <= 1'b0;
         external_vector_bus_out <= '0;
         external_vector_bus_oe <= 1'b0;
      end else begin
         // New address or control breaks any burst
         if (take && req_prev == VT_ADDR && turn_cnt == 2'h0) begin
            seq_ok <= 1'b0;
         end
         // drivers off except during read data
         if (take && req_prev != VT_RD) begin
            external_vector_bus_oe <= 1'b0;
         end
         case (ab)
            AB_IDLE: begin
               // only validated transfers reach the bus
               if (pend && hgrant && hready) begin
                  ab <= AB_ADDR;
                  haddr <= cur_addr;
                  hwrite <= dir;
                  htrans <= (seq_ok && dir == last_dir) ? TR_SEQ : TR_NSEQ;
               end
            end
            AB_ADDR: begin
               if (hready) begin
                  ab <= AB_DATA;
                  htrans <= TR_IDLE;
                  hwdata <= wdata_q;
                  last_dir <= hwrite;
                  seq_ok <= inc_cfg && !seg_inc[8];
               end
            end
            AB_DATA: begin
               if (hready) begin
                  ab <= AB_IDLE;
                  if (!hwrite) begin
                     external_vector_bus_out <= hrdata;
                     external_vector_bus_oe <= 1'b1;
                  end
               end
            end
            default: ab <= AB_IDLE;
         endcase
      end
   end

   // Size and protection follow the control settings, lock only in ST_RUN; burst stays fixed at BURST_INCR
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hsize <= {1'b0, SIZE_RST};
         hprot <= PROT_RST;
         hburst <= BURST_INCR;
         hlock <= 1'b0;
      end else begin
         hsize <= {1'b0, size_cfg};
         hprot <= prot_cfg;
         hburst <= BURST_INCR;
         hlock <= lock_cfg && (mode == ST_RUN);
      end
   end

   // =====================================================================
   // APB registers
   // =====================================================================
   // One wait state; unmapped addresses answer with pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en <= CTRL_EN_RST;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && penable && !pready) begin
            case (paddr)
               OFF_CTRL: begin
                  if (pwrite) begin
                     ctrl_en <= pwdata[0];
                  end
                  prdata <= {31'h0, ctrl_en};
               end
               OFF_STAT: prdata <= {25'h0, external_vector_bus_oe, addr_valid,
                  tester_acknowledge, ab, mode};
               OFF_ADDR: prdata <= 32'(cur_addr);
               OFF_CFG: prdata <= {21'h0, prot_cfg[3:2], 1'b0, inc_cfg,
                  prot_cfg[1:0], lock_cfg, size_cfg, 2'h0};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // =====================================================================
   // Assertions
   // =====================================================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   idle_ack_low_a:
      assert property (mode == ST_IDLE |-> !tester_acknowledge && !hbusreq)
      else $error("acknowledge or request active while idle");
   ack_after_grant_a:
      assert property ($rose(tester_acknowledge) |-> mode == ST_RUN && $past(hgrant))
      else $error("acknowledge without grant");
   stall_drops_ack_a:
      assert property (tick && busy && mode == ST_RUN |=> !tester_acknowledge)
      else $error("acknowledge stayed high while busy");
   size_top_low_a:
      assert property (!hsize[2] && hburst == BURST_INCR)
      else $error("bad size or burst");
   xfer_needs_addr_a:
      assert property (htrans != TR_IDLE |-> addr_valid)
      else $error("transfer before an address");
   write_data_out_a:
      assert property (ab == AB_ADDR && hready && hwrite |=> hwdata == $past(wdata_q))
      else $error("write data not driven");
   fixed_addr_a:
      assert property (ab == AB_ADDR && hready && !inc_cfg |=> $stable(cur_addr))
      else $error("address moved with increment off");
   ctrl_ignored_a:
      assert property (take && is_ctrl && !bus_s3[CV_VALID] |=> $stable(size_cfg)
         && $stable(prot_cfg) && $stable(inc_cfg))
      else $error("invalid control vector applied");
   wrap_nonseq_a:
      assert property (ab == AB_ADDR && hready && seg_inc[8] |=> !seq_ok)
      else $error("wrap left burst sequential");
   drive_only_read_a:
      assert property (external_vector_bus_oe |-> !last_dir)
      else $error("bus driven outside read");

   enter_run_c: cover property (mode == ST_START ##1 mode == ST_RUN);
   read_done_c: cover property ($rose(external_vector_bus_oe));
   write_done_c: cover property (ab == AB_DATA && hready && hwrite);
   ctrl_set_c: cover property (take && is_ctrl && bus_s3[CV_VALID]);
endmodule

// *** sim/vector_tester.sv ***
// =====================================================================
// Synchronous tester model for the test vector bus master
// =====================================================================
// Drives the request pins, the tester clock and its side of the vector bus.
// Assumes the bench resolves the shared bus and calls enter and step in order.
module vector_tester
   import test_vector_pkg::*;
(
   input wire logic pclk,
   input wire logic tester_acknowledge,
   input wire logic [31:0] bus_level,
   input wire logic bus_oe,
   output logic external_test_clock,
   output logic tester_req_primary,
   output logic tester_req_secondary,
   output logic drive_en,
   output logic [31:0] drive_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] seen; // Bus level just before the last rising edge
   logic seen_oe; // Device drive state at that moment
   int retries; // Edges repeated because a transfer was busy
   bit exiting = 1'b0; // Exit type announced, acknowledge will stay low
   localparam int ENTRY_PULSES = 4; // Tester cycles sure to win the bus

   initial begin
      external_test_clock = 1'b0;
      tester_req_primary = 1'b0;
      tester_req_secondary = 1'b0;
      drive_en = 1'b0;
      drive_data = 32'h0;
      retries = 0;
   end

   // =====================================================================
   // Clock pulse
   // =====================================================================
   // One 64 ns tester cycle, capturing the bus just before the edge
   task automatic pulse();
      repeat (4) @(posedge pclk);
      seen = bus_level;
      seen_oe = bus_oe;
      external_test_clock <= 1'b1;
      repeat (4) @(posedge pclk);
      external_test_clock <= 1'b0;
   endtask

   task automatic enter();
      tester_req_primary <= 1'b1;
      tester_req_secondary <= 1'b0;
      // No polling: the bench looks at acknowledge afterwards
      repeat (ENTRY_PULSES) pulse();
   endtask

   // pins name the next cycle's bus contents
   task automatic step(input logic [1:0] vt, input bit drv, input logic [31:0] d);
      bit miss;
      {tester_req_primary, tester_req_secondary} <= vt;
      drive_en <= drv;
      drive_data <= d;
      // repeat the vector while acknowledge is low
      do begin
         pulse();
         miss = 0;
         repeat (3) begin
            @(posedge pclk);
            if (tester_acknowledge !== 1'b1) miss = 1;
         end
         // The exit cycle leaves acknowledge low for good, so no wait there
         while (tester_acknowledge !== 1'b1 && !exiting) begin
            @(posedge pclk);
            miss = 1;
         end
         if (miss) retries++;
      end while (miss && !exiting);
      exiting = (vt == VT_EXIT);
   endtask
endmodule

// *** sim/test_vector_bus_master_tb.sv ***
// =====================================================================
// Self-checking bench for the test vector bus master
// =====================================================================
// Holds the clock, APB tasks, a bus slave with arbiter and the sequence.
// Assumes the tester model in vector_tester and the package constants.
module test_vector_bus_master_tb;
   import test_vector_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd, bus, bus_out, last = 32'h0, hwdata, haddr;
   logic pready, pslverr, err, tclk, req_p, req_s, ack, oe, drv, hbusreq, hlock;
   logic hgrant = 1'b0, hready, hwrite;
   logic [31:0] tdata, hrdata, mem [0:255];
   logic [1:0] htrans;
   logic [1:0] last_tr = 2'h0; // Transfer type of the latest address phase
   logic [2:0] hsize, hburst;
   logic [3:0] hprot;
   logic dph = 1'b0, dwr = 1'b0;
   logic [7:0] didx = 8'h0;
   int wcnt = 0, wait_n = 0, nxfer = 0, fail_count = 0, compares = 0, cycles = 0;

   always #4 pclk = ~pclk;

   // Released bus shows the inverse of its last level
   assign bus = oe ? bus_out : (drv ? tdata : ~last);
   always @(posedge pclk) if (oe || drv) last <= bus;

   // =====================================================================
   // Bus slave and arbiter
   // =====================================================================
   // Grants on request, waits wait_n cycles in each data phase
   assign hready = !(dph && wcnt != 0);
   assign hrdata = (dph && !dwr) ? mem[didx] : ~mem[didx];
   initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
   always @(posedge pclk) begin
      hgrant <= hbusreq;
      if (dph && wcnt != 0) begin
         wcnt <= wcnt - 1;
      end else begin
         if (dph && dwr) mem[didx] <= hwdata;
         dph <= htrans[1];
         didx <= haddr[9:2];
         dwr <= hwrite;
         wcnt <= wait_n;
         if (htrans[1]) nxfer <= nxfer + 1;
         if (htrans[1]) last_tr <= htrans;
      end
   end

   test_vector_bus_master uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_test_clock(tclk), .tester_req_primary(req_p),
      .tester_req_secondary(req_s), .tester_acknowledge(ack),
      .external_vector_bus_in(bus), .external_vector_bus_out(bus_out),
      .external_vector_bus_oe(oe), .hbusreq(hbusreq), .hlock(hlock), .hgrant(hgrant),
      .hready(hready), .hresp(2'h0), .hrdata(hrdata), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hburst(hburst), .hprot(hprot), .hwdata(hwdata));

   vector_tester tester (.pclk(pclk), .tester_acknowledge(ack), .bus_level(bus),
      .bus_oe(oe), .external_test_clock(tclk), .tester_req_primary(req_p),
      .tester_req_secondary(req_s), .drive_en(drv), .drive_data(tdata));

   // =====================================================================
   // Checking and closing
   // =====================================================================
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Cuts a hang short
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         give_verdict();
      end
   end

   // APB transfer: setup, access, hold until pready
   task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends on pready; with no local limit, only the bench timeout ends a hang here
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      check(32'({ack, hbusreq, oe, htrans}), 32'h0, "idle outputs");
      check(32'({hsize, hprot}), 32'({SIZE_RST, PROT_RST}), "reset ctrl");
      check(32'(hburst), 32'(BURST_INCR), "burst");
      apb(1'b0, OFF_CTRL, 32'h0);
      check(rd, 32'(CTRL_EN_RST), "ctrl reg");
      apb(1'b0, 12'hFF0, 32'h0);
      check(32'(err), 32'h1, "unmapped");
      apb(1'b1, 12'hFF0, 32'h0);
      check(32'(err), 32'h1, "unmapped wr");
      // Entry refused while the enable bit is clear
      apb(1'b1, OFF_CTRL, 32'h0);
      tester.enter();
      check(32'({ack, hbusreq}), 32'h0, "entry refused");
      apb(1'b1, OFF_CTRL, 32'h1);
      tester.enter();
      check(32'({ack, hbusreq}), 32'h3, "entry");
      tester.step(VT_ADDR, 1'b0, 32'h0);
      check(32'(nxfer), 32'h0, "early xfer");
      tester.step(VT_WR, 1'b1, 32'h0000_0040);
      tester.step(VT_WR, 1'b1, 32'h1111_0000);
      tester.step(VT_ADDR, 1'b1, 32'h2222_0001);
      apb(1'b0, OFF_ADDR, 32'h0);
      check(rd, 32'h0000_0040, "address");
      check(mem[16], 32'h2222_0001, "same addr write");
      check(mem[17], 32'h0, "no increment");
      // lock set ahead of the writes
      tester.step(VT_ADDR, 1'b1, 32'h0000_0080);
      tester.step(VT_WR, 1'b1, 32'h0000_04F9);
      check(32'({hlock, hprot, hsize}), 32'({1'b1, 4'hB, 3'h2}), "control");
      apb(1'b0, OFF_CFG, 32'h0);
      check(rd, 32'h0000_04F8, "cfg reg");
      tester.step(VT_WR, 1'b1, 32'h3333_0002);
      tester.step(VT_ADDR, 1'b1, 32'h4444_0003);
      check(32'(last_tr), 32'(TR_SEQ), "burst seq");
      // Word burst across the incrementer boundary wraps to zero
      tester.step(VT_WR, 1'b1, 32'h0000_03FC);
      tester.step(VT_WR, 1'b1, 32'h5555_0004);
      tester.step(VT_ADDR, 1'b1, 32'h6666_0005);
      check(mem[255], 32'h5555_0004, "wrap first");
      check(mem[0], 32'h6666_0005, "wrap second");
      check(32'(last_tr), 32'(TR_NSEQ), "wrap nonseq");
      tester.step(VT_ADDR, 1'b1, 32'h0000_0040);
      check(mem[32], 32'h3333_0002, "burst first");
      check(mem[33], 32'h4444_0003, "burst second");
      tester.step(VT_RD, 1'b1, 32'h0000_0000);
      check(32'({hlock, hsize}), 32'({1'b1, 3'h2}), "invalid ctrl");
      wait_n = 12;
      tester.step(VT_ADDR, 1'b0, 32'h0);
      // two turnaround vectors after the read
      tester.step(VT_ADDR, 1'b0, 32'h0);
      // Read data is seen at the edge that ends the first turnaround
      check({31'h0, tester.seen_oe}, 32'h1, "read oe");
      check(tester.seen, 32'h2222_0001, "read data");
      check(32'(tester.retries > 0), 32'h1, "busy retry");
      check(32'(hwrite), 32'h0, "read dir");
      tester.step(VT_ADDR, 1'b0, 32'h0);
      check({31'h0, tester.seen_oe}, 32'h0, "turnaround oe");
      tester.step(VT_EXIT, 1'b1, 32'h0000_0040);
      tester.step(VT_EXIT, 1'b0, 32'h0);
      repeat (20) @(posedge pclk);
      check(32'({ack, hbusreq}), 32'h0, "exit");
      give_verdict();
   end
endmodule
